// ==== inc/sai_defines.vh ====
// constants for the serial audio input receiver
`ifndef SAI_DEFINES_VH
`define SAI_DEFINES_VH

`define SAI_ADDR_FORMAT 8'h35
`define SAI_ADDR_SERIAL 8'h36

`define SAI_FMT_W 3
`define SAI_FMT_I2S 3'h0
`define SAI_FMT_LJ 3'h1
`define SAI_FMT_RJ16 3'h4
`define SAI_FMT_RJ18 3'h5
`define SAI_FMT_RJ20 3'h6
`define SAI_FMT_RJ24 3'h7
`define SAI_FMT_RJ_BIT 2
`define SAI_FMT_RESET 3'h1

`define SAI_SER_W 6
`define SAI_SER_RESET 6'h01
`define SAI_SCK_POL_RESET 1'b1
`define SAI_BIT_SCK_POL 0
`define SAI_BIT_WS_POL 1
`define SAI_BIT_LSB_FIRST 2
`define SAI_BIT_FRAME_LO 3
`define SAI_BIT_FRAME_HI 4
`define SAI_BIT_RIGHT_FIRST 5

`define SAI_FRAME_64 2'h0
`define SAI_FRAME_48 2'h1
`define SAI_FRAME_32 2'h2

`define SAI_WORD_BITS_64 6'h20
`define SAI_WORD_BITS_48 6'h18
`define SAI_WORD_BITS_32 6'h10
`define SAI_WORD_BITS_BAD 6'h00

`define SAI_RJ_16 6'h10
`define SAI_RJ_18 6'h12
`define SAI_RJ_20 6'h14
`define SAI_RJ_24 6'h18

`define SAI_SHIFT_W 32
`define SAI_SHIFT_FULL 6'h20
`define SAI_SAMPLE_W 24
`define SAI_SAMPLE_BITS 6'h18
`define SAI_FIFO_DEPTH 4
`define SAI_FIFO_AW 2

`endif

// ==== rtl/sai_fifo.v ====
// small synchronous fifo with valid/ready on both sides
module sai_fifo #(
  parameter WIDTH = 96,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk, // system clock
  input wire sys_rst, // synchronous reset, active high
  input wire in_valid, // write request
  output wire in_ready, // space available
  input wire [WIDTH-1:0] in_data, // write data
  output wire out_valid, // data available
  input wire out_ready, // read acknowledge
  output wire [WIDTH-1:0] out_data // head of queue
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_wr;
  wire do_rd;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  always @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                  wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                  rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ==== rtl/sai_rx.v ====
// slave receiver for the four-channel serial pcm audio input
`include "sai_defines.vh"

// Notes on behaviour
// - serial audio lines are inputs only; receiver never drives them.
// - data line zero carries pair zero, line one carries pair one.
// - format 000 is i2s, 001 left-justified; left-justified after reset.
// - formats 100 to 111 are right-justified at 16, 18, 20, 24 bits.
// - edge bit 1, reset value: source changes falling, sample on rising.
// - frame length 00 is 64, 01 is 48, 10 is 32; 11 reserved.
// - select polarity 0: first word while select low; 1: while high.
// - bit order 0 sends msb first, 1 sends lsb first.
// - channel order 0 puts left word first, 1 puts right first.
// - every framing option is a software register, not fixed.
module sai_rx #(
  parameter FIFO_DEPTH = `SAI_FIFO_DEPTH,
  parameter FIFO_AW = `SAI_FIFO_AW
) (
  input wire clk, // system clock, 40 mhz
  input wire sys_rst, // synchronous reset, active high
  input wire bit_clock, // serial bit clock from the source
  input wire word_select, // left/right word select
  input wire serial_data_pair_zero, // serial data, pair zero
  input wire serial_data_pair_one, // serial data, pair one
  input wire [7:0] reg_addr, // register address
  input wire [7:0] reg_wdata, // register write data
  input wire reg_wr, // register write strobe
  output reg [7:0] reg_rdata, // register read data
  output reg out_valid, // a sample frame is presented
  input wire out_ready, // consumer takes the frame
  output reg [`SAI_SAMPLE_W-1:0] out_left0, // pair zero left
  output reg [`SAI_SAMPLE_W-1:0] out_right0, // pair zero right
  output reg [`SAI_SAMPLE_W-1:0] out_left1, // pair one left
  output reg [`SAI_SAMPLE_W-1:0] out_right1, // pair one right
  output reg overrun, // frame dropped, fifo full
  output reg frame_error // word length did not match the frame
);
  localparam FRAME_W = 4 * `SAI_SAMPLE_W;

  // configuration registers
  reg [`SAI_FMT_W-1:0] pcm_word_format;
  reg clock_edge_select;
  reg word_select_polarity;
  reg sample_bit_order;
  reg [1:0] frame_length_select;
  reg channel_order_select;

  // synchronised pins; only inputs, nothing here drives them
  wire [3:0] pins_sync;
  wire sck_s;
  wire ws_s;
  wire sd0_s;
  wire sd1_s;

  reg sck_prev;
  wire sample_edge;
  wire is_i2s;
  wire is_rj;
  wire eff_ws;

  reg ws_dly;
  reg eff_prev;
  reg [`SAI_SHIFT_W-1:0] sh0;
  reg [`SAI_SHIFT_W-1:0] sh1;
  reg [5:0] cnt;
  reg [5:0] expected;
  reg [5:0] rj_n;

  reg have_first;
  reg [`SAI_SAMPLE_W-1:0] first0;
  reg [`SAI_SAMPLE_W-1:0] first1;
  reg push_valid;
  reg [FRAME_W-1:0] push_data;

  wire [`SAI_SAMPLE_W-1:0] word0;
  wire [`SAI_SAMPLE_W-1:0] word1;
  wire word_good;
  wire word_first;

  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [FRAME_W-1:0] fifo_out_data;

  sai_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din({serial_data_pair_one, serial_data_pair_zero, word_select,
          bit_clock}),
    .dout(pins_sync)
  );

  assign sck_s = pins_sync[0];
  assign ws_s = pins_sync[1];
  assign sd0_s = pins_sync[2];
  assign sd1_s = pins_sync[3];

  // shift one bit into a word, in the selected bit order
  function [`SAI_SHIFT_W-1:0] shift_in;
    input [`SAI_SHIFT_W-1:0] sh;
    input b;
    input lsb;
    begin
      if (lsb) begin
        shift_in = {b, sh[`SAI_SHIFT_W-1:1]};
      end else begin
        shift_in = {sh[`SAI_SHIFT_W-2:0], b};
      end
    end
  endfunction

  // recover a left-aligned sample from a finished word
  function [`SAI_SAMPLE_W-1:0] extract;
    input [`SAI_SHIFT_W-1:0] sh;
    input [5:0] len;
    input rj;
    input [5:0] n;
    input lsb;
    reg [`SAI_SHIFT_W-1:0] w;
    reg [`SAI_SHIFT_W-1:0] r;
    begin
      w = {`SAI_SHIFT_W{1'b0}};
      r = {`SAI_SHIFT_W{1'b0}};
      if (rj) begin
        // last n bits before the select change
        if (lsb) begin
          w = sh >> (`SAI_SHIFT_FULL - n);
        end else begin
          w = sh;
        end
        w = w & ((32'h00000001 << n) - 32'h00000001);
        r = w << (`SAI_SAMPLE_BITS - n);
      end else begin
        // first bits after the word starts
        if (lsb) begin
          w = sh >> (`SAI_SHIFT_FULL - len);
        end else begin
          w = sh;
        end
        if (len >= `SAI_SAMPLE_BITS) begin
          r = w >> (len - `SAI_SAMPLE_BITS);
        end else begin
          r = w << (`SAI_SAMPLE_BITS - len);
        end
      end
      extract = r[`SAI_SAMPLE_W-1:0];
    end
  endfunction

  // register writes and read-back
  always @(posedge clk) begin
    if (sys_rst) begin
      pcm_word_format <= `SAI_FMT_RESET;
      clock_edge_select <= `SAI_SCK_POL_RESET;
      word_select_polarity <= 1'b0;
      sample_bit_order <= 1'b0;
      frame_length_select <= `SAI_FRAME_64;
      channel_order_select <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == `SAI_ADDR_FORMAT) begin
        pcm_word_format <= reg_wdata[`SAI_FMT_W-1:0];
      end
      if (reg_wr && reg_addr == `SAI_ADDR_SERIAL) begin
        clock_edge_select <= reg_wdata[`SAI_BIT_SCK_POL];
        word_select_polarity <= reg_wdata[`SAI_BIT_WS_POL];
        sample_bit_order <= reg_wdata[`SAI_BIT_LSB_FIRST];
        frame_length_select <=
          reg_wdata[`SAI_BIT_FRAME_HI:`SAI_BIT_FRAME_LO];
        channel_order_select <= reg_wdata[`SAI_BIT_RIGHT_FIRST];
      end
      if (reg_addr == `SAI_ADDR_FORMAT) begin
        reg_rdata <= {5'h00, pcm_word_format};
      end else if (reg_addr == `SAI_ADDR_SERIAL) begin
        reg_rdata <= {2'h0, channel_order_select, frame_length_select,
                      sample_bit_order, word_select_polarity,
                      clock_edge_select};
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // decode of format and frame length
  always @* begin
    case (frame_length_select)
      `SAI_FRAME_64: expected = `SAI_WORD_BITS_64;
      `SAI_FRAME_48: expected = `SAI_WORD_BITS_48;
      `SAI_FRAME_32: expected = `SAI_WORD_BITS_32;
      default: expected = `SAI_WORD_BITS_BAD;
    endcase
    case (pcm_word_format)
      `SAI_FMT_RJ16: rj_n = `SAI_RJ_16;
      `SAI_FMT_RJ18: rj_n = `SAI_RJ_18;
      `SAI_FMT_RJ20: rj_n = `SAI_RJ_20;
      `SAI_FMT_RJ24: rj_n = `SAI_RJ_24;
      default: rj_n = `SAI_RJ_24;
    endcase
  end

  assign is_i2s = (pcm_word_format == `SAI_FMT_I2S);
  assign is_rj = pcm_word_format[`SAI_FMT_RJ_BIT];

  // sample edge chosen by the clock-edge bit
  assign sample_edge = clock_edge_select ? (sck_s && !sck_prev)
                                         : (!sck_s && sck_prev);

  // i2s words start one bit after the select change
  assign eff_ws = is_i2s ? ws_dly : ws_s;

  assign word0 = extract(sh0, cnt, is_rj, rj_n, sample_bit_order);
  assign word1 = extract(sh1, cnt, is_rj, rj_n, sample_bit_order);
  assign word_good = (cnt == expected);
  assign word_first = (eff_prev == word_select_polarity);

  // bit capture and word assembly
  always @(posedge clk) begin
    if (sys_rst) begin
      sck_prev <= 1'b0;
      ws_dly <= 1'b0;
      eff_prev <= 1'b0;
      sh0 <= {`SAI_SHIFT_W{1'b0}};
      sh1 <= {`SAI_SHIFT_W{1'b0}};
      cnt <= 6'h00;
      have_first <= 1'b0;
      first0 <= {`SAI_SAMPLE_W{1'b0}};
      first1 <= {`SAI_SAMPLE_W{1'b0}};
      push_valid <= 1'b0;
      push_data <= {FRAME_W{1'b0}};
      frame_error <= 1'b0;
    end else begin
      sck_prev <= sck_s;
      push_valid <= 1'b0;
      frame_error <= 1'b0;
      if (sample_edge) begin
        ws_dly <= ws_s;
        eff_prev <= eff_ws;
        if (eff_ws != eff_prev) begin
          // word boundary: close the previous word, start a new one
          sh0 <= shift_in({`SAI_SHIFT_W{1'b0}}, sd0_s, sample_bit_order);
          sh1 <= shift_in({`SAI_SHIFT_W{1'b0}}, sd1_s, sample_bit_order);
          cnt <= 6'h01;
          frame_error <= !word_good;
          if (word_first) begin
            first0 <= word0;
            first1 <= word1;
            have_first <= word_good;
          end else begin
            have_first <= 1'b0;
            push_valid <= have_first && word_good;
            if (channel_order_select) begin
              push_data <= {word0, first0, word1, first1};
            end else begin
              push_data <= {first0, word0, first1, word1};
            end
          end
        end else begin
          sh0 <= shift_in(sh0, sd0_s, sample_bit_order);
          sh1 <= shift_in(sh1, sd1_s, sample_bit_order);
          if (cnt != `SAI_SHIFT_FULL) begin
            cnt <= cnt + 6'h01;
          end
        end
      end
    end
  end

  sai_fifo #(
    .WIDTH(FRAME_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // registered output stage drains the fifo
  assign fifo_out_ready = !out_valid || out_ready;

  always @(posedge clk) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      out_left0 <= {`SAI_SAMPLE_W{1'b0}};
      out_right0 <= {`SAI_SAMPLE_W{1'b0}};
      out_left1 <= {`SAI_SAMPLE_W{1'b0}};
      out_right1 <= {`SAI_SAMPLE_W{1'b0}};
      overrun <= 1'b0;
    end else begin
      // the source cannot be stalled, so a full fifo drops the frame
      overrun <= push_valid && !fifo_in_ready;
      if (fifo_out_ready) begin
        out_valid <= fifo_out_valid;
        if (fifo_out_valid) begin
          out_left0 <= fifo_out_data[4*`SAI_SAMPLE_W-1:3*`SAI_SAMPLE_W];
          out_right0 <= fifo_out_data[3*`SAI_SAMPLE_W-1:2*`SAI_SAMPLE_W];
          out_left1 <= fifo_out_data[2*`SAI_SAMPLE_W-1:`SAI_SAMPLE_W];
          out_right1 <= fifo_out_data[`SAI_SAMPLE_W-1:0];
        end
      end
    end
  end
endmodule

// ==== rtl/sai_sync.v ====
// two-flop synchroniser for a group of asynchronous inputs
module sai_sync #(
  parameter WIDTH = 4
) (
  input wire clk, // system clock
  input wire sys_rst, // synchronous reset, active high
  input wire [WIDTH-1:0] din, // asynchronous inputs
  output reg [WIDTH-1:0] dout // synchronised inputs
);
  reg [WIDTH-1:0] meta;

  always @(posedge clk) begin
    if (sys_rst) begin
      meta <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// ==== sim/sai_rx_bench.sv ====
// self-checking bench for the serial audio input receiver
module sai_rx_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic out_ready = 1'b0;
  wire [7:0] reg_rdata;
  wire out_valid, overrun, frame_error, bclk, ws, sd0, sd1;
  wire [23:0] o_l0, o_r0, o_l1, o_r1;
  int err_total = 0;
  int n_checks = 0;
  int n_ovr = 0;
  int n_fe = 0;
  int k, m, w, n;
  logic [31:0] l0, r0, l1, r1;
  logic [2:0] fmts [0:11] = '{0: 3'h1, 1: 3'h0, 2: 3'h4, 3: 3'h5,
    4: 3'h6, 5: 3'h7, 11: 3'h0, default: 3'h1};
  logic [7:0] cfgs [0:11] = '{6: 8'h00, 7: 8'h09, 8: 8'h11, 9: 8'h03,
    10: 8'h05, 11: 8'h21, default: 8'h01};
  sai_src u_src (.bclk(bclk), .ws(ws), .sd0(sd0), .sd1(sd1));
  // serial lines are inputs of the receiver only
  sai_rx u_sai_rx (.clk(clk), .sys_rst(sys_rst), .bit_clock(bclk),
    .word_select(ws), .serial_data_pair_zero(sd0),
    .serial_data_pair_one(sd1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .out_valid(out_valid), .out_ready(out_ready), .out_left0(o_l0),
    .out_right0(o_r0), .out_left1(o_l1), .out_right1(o_r1),
    .overrun(overrun), .frame_error(frame_error));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    n_ovr <= n_ovr + (overrun === 1'b1);
    n_fe <= n_fe + (frame_error === 1'b1);
  end
  function automatic [23:0] ex(input [31:0] v, input int w, n);
    logic [31:0] t;
    t = v & ((32'h1 << w) - 32'h1);
    if (n != 0) ex = (t & ((32'h1 << n) - 32'h1)) << (24 - n);
    else if (w >= 24) ex = t >> (w - 24);
    else ex = t << (24 - w);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    chk("rdata", {24'h0, reg_rdata}, {24'h0, exp});
  endtask
  task automatic take(input int w, n);
    m = 0;
    while (out_valid !== 1'b1 && m < 100) begin
      @(negedge clk);
      m++;
    end
    chk("l0", o_l0, ex(l0, w, n));
    chk("r0", o_r0, ex(r0, w, n));
    chk("l1", o_l1, ex(l1, w, n));
    chk("r1", o_r1, ex(r1, w, n));
    out_ready = 1'b1;
    @(negedge clk);
    out_ready = 1'b0;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #2_000_000;
    err_total++;
    final_report;
  end
  initial begin
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    rd(8'h35, 8'h01);
    rd(8'h36, 8'h01);
    rd(8'h37, 8'h00);
    wr(8'h35, 8'hFE);
    rd(8'h35, 8'h06);
    wr(8'h36, 8'hFF);
    rd(8'h36, 8'h3F);
    for (k = 0; k < 12; k++) begin
      wr(8'h35, {5'h00, fmts[k]});
      wr(8'h36, cfgs[k]);
      w = cfgs[k][4:3] == 2'h1 ? 24 : cfgs[k][4:3] == 2'h2 ? 16 : 32;
      n = !fmts[k][2] ? 0 : fmts[k] == 3'h7 ? 24 : 16 + 2 * fmts[k][1:0];
      l0 = 32'hC3A51E0F + k * 32'h01010101;
      r0 = ~l0;
      l1 = {l0[15:0], l0[31:16]};
      r1 = l0 ^ 32'h5A5A5A5A;
      u_src.frame(cfgs[k], fmts[k] == 3'h0, l0, r0, l1, r1);
      take(w, n);
    end
    wr(8'h35, 8'h01);
    wr(8'h36, 8'h19);
    k = n_fe;
    u_src.frame(8'h19, 1'b0, l0, r0, l1, r1);
    repeat (20) @(negedge clk);
    chk("rsv valid", {31'h0, out_valid}, 32'h0);
    chk("rsv error", {31'h0, n_fe > k}, 32'h1);
    wr(8'h36, 8'h01);
    for (k = 0; k < 6; k++) u_src.frame(8'h01, 1'b0, l0, r0, l1, r1);
    repeat (20) @(negedge clk);
    chk("overrun", {31'h0, n_ovr > 0}, 32'h1);
    k = 0;
    while (out_valid === 1'b1 && k < 8) begin
      take(32, 0);
      k++;
    end
    chk("frames", k + n_ovr, 6);
    final_report;
  end
endmodule

// ==== sim/sai_rx_properties.sv ====
// assertions on the ports of the serial audio input receiver
`include "sai_defines.vh"
module sai_rx_properties #(
  parameter FIFO_DEPTH = `SAI_FIFO_DEPTH,
  parameter FIFO_AW = `SAI_FIFO_AW
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic bit_clock, // serial bit clock
  input wire logic word_select, // word select
  input wire logic serial_data_pair_zero, // data pair zero
  input wire logic serial_data_pair_one, // data pair one
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic out_valid, // frame presented
  input wire logic out_ready, // frame taken
  input wire logic [`SAI_SAMPLE_W-1:0] out_left0, // pair zero left
  input wire logic [`SAI_SAMPLE_W-1:0] out_right0, // pair zero right
  input wire logic [`SAI_SAMPLE_W-1:0] out_left1, // pair one left
  input wire logic [`SAI_SAMPLE_W-1:0] out_right1, // pair one right
  input wire logic overrun, // frame dropped
  input wire logic frame_error // bad word length
);
  timeunit 1ns;
  timeprecision 1ps;
  logic bc_q;
  logic [4:0] since;
  // cycles since the bit clock last moved
  always @(posedge clk) begin
    bc_q <= bit_clock;
    if (sys_rst || bc_q != bit_clock) since <= 5'h00;
    else if (since != 5'h1F) since <= since + 5'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_unmapped_reads_zero: assert property (
    reg_addr != 8'h35 && reg_addr != 8'h36 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_format_readback: assert property (
    reg_wr && reg_addr == 8'h35 ##1 !reg_wr && reg_addr == 8'h35
    |=> reg_rdata == {5'h00, $past(reg_wdata[2:0], 2)})
    else $error("format readback wrong");
  a_serial_readback: assert property (
    reg_wr && reg_addr == 8'h36 ##1 !reg_wr && reg_addr == 8'h36
    |=> reg_rdata == {2'h0, $past(reg_wdata[5:0], 2)})
    else $error("serial config readback wrong");
  a_frame_holds: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_left0)
    && $stable(out_right0) && $stable(out_left1) && $stable(out_right1))
    else $error("frame changed before taken");
  a_reset_values: assert property (
    $fell(sys_rst) |-> !out_valid && !overrun && !frame_error
    && reg_rdata == 8'h00) else $error("outputs not cleared by reset");
  a_overrun_full: assert property (overrun |-> out_valid)
    else $error("overrun without pending frame");
  a_overrun_pulse: assert property (overrun |=> !overrun)
    else $error("overrun longer than one cycle");
  a_error_pulse: assert property (
    frame_error |=> !frame_error) else $error("error pulse too long");
  a_error_after_edge: assert property (
    frame_error |-> since < 5'h10) else $error("error without clock edge");
  a_frame_after_edge: assert property (
    $rose(out_valid) |-> since < 5'h10)
    else $error("frame without bit clock edge");
endmodule

bind sai_rx sai_rx_properties #(.FIFO_DEPTH(FIFO_DEPTH),
  .FIFO_AW(FIFO_AW)) u_sai_rx_properties (.clk(clk), .sys_rst(sys_rst),
  .bit_clock(bit_clock), .word_select(word_select),
  .serial_data_pair_zero(serial_data_pair_zero),
  .serial_data_pair_one(serial_data_pair_one), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
  .out_valid(out_valid), .out_ready(out_ready), .out_left0(out_left0),
  .out_right0(out_right0), .out_left1(out_left1),
  .out_right1(out_right1), .overrun(overrun), .frame_error(frame_error));

// ==== sim/sai_src.sv ====
// audio source model driving the serial audio lines
module sai_src (
  output logic bclk, // bit clock, still between frames
  output logic ws, // word select
  output logic sd0, // data pair zero
  output logic sd1 // data pair one
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    bclk = 1'b0;
    ws = 1'b0;
    sd0 = 1'b0;
    sd1 = 1'b0;
  end
  task automatic frame(input logic [7:0] c, input logic lag,
    input logic [31:0] l0, r0, l1, r1);
    int w, q, i;
    logic [31:0] v0, v1;
    w = c[4:3] == 2'h1 ? 24 : c[4:3] == 2'h2 ? 16 : 32;
    bclk = ~c[0];
    for (int p = -2; p <= 2 * w; p++) begin
      q = p + lag;
      ws = c[1] ^ (q < 0 || (q >= w && q < 2 * w));
      if (p >= 0 && p < 2 * w) begin
        v0 = ((p < w) ^ c[5]) ? l0 : r0;
        v1 = ((p < w) ^ c[5]) ? l1 : r1;
        i = c[2] ? p % w : w - 1 - p % w;
        sd0 = v0[i];
        sd1 = v1[i];
      end else begin
        // outside words the lines keep moving
        sd0 = ~sd0;
        sd1 = ~sd1;
      end
      #100 bclk = c[0];
      #100 bclk = ~c[0];
    end
  endtask
endmodule
